// ---- logic/video_field_converter.sv ----
// Purpose: turn progressive frames into interlaced fields, one field per frame
// Assumes: source marks frame and line starts with sync flags; static dimensions
// Notes: one output register stage; reset clears state while held
`timescale 1ns/1ps
module video_field_converter
    import field_conv_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // static frame format
    input wire logic [DIM_W-1:0] lineWidth,
    input wire logic [DIM_W-1:0] frameHeight,
    // input stream
    input wire pix_in_t pixIn,
    input wire logic pixInValid,
    output logic pixInReady,
    // output stream
    output pix_out_t pixOut,
    output logic pixOutValid,
    input wire logic pixOutReady
);
    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the carriers are fixed at 24-bit pixels and 16-bit dimensions
    if (PIX_W != 24 || DIM_W != 16) begin : g_width_check
        $error("unsupported widths");
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    // odd field keeps lines 0,2,.. even keeps 1,3,..
    function automatic logic lineKept(
        input logic [DIM_W-1:0] lineIdx,
        input logic fieldIdx,
        input logic [DIM_W-1:0] height
    );
        return (lineIdx[0] == fieldIdx) && (lineIdx < height);
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [DIM_W-1:0] pixCnt_reg, pixCnt_next;
    logic [DIM_W-1:0] lineCnt_reg, lineCnt_next;
    logic field_reg, field_next;
    logic firstOut_reg, firstOut_next;
    logic started_reg, started_next;
    pix_out_t out_reg, out_next;
    logic outValid_reg, outValid_next;
    pix_out_t skid_reg, skid_next;
    logic skidValid_reg, skidValid_next;
    logic inReady_reg, inReady_next;
    logic take, keep, slotFree, lastPix, firstPix;
    logic [DIM_W-1:0] curLine;
    logic curField;
    pix_out_t word;

    // ****************************************************************
    // position in the frame
    // ****************************************************************
    always_comb begin
        take = pixInValid && pixInReady;
        // frame start resets position, also recovers from a short frame
        curLine = pixIn.frameSync ? DIM_ZERO
                : (pixIn.lineSync && started_reg) ? lineCnt_reg + DIM_ONE : lineCnt_reg;
        // field flips at each new frame after the first pixel taken since reset
        curField = (pixIn.frameSync && started_reg) ? ~field_reg : field_reg;
        // frame size read straight from the static inputs
        // only lines inside the frame height count
        keep = take && lineKept(curLine, curField, frameHeight);
        lastPix = (pixIn.lineSync ? DIM_ZERO : pixCnt_reg) == lineWidth - DIM_ONE;
        firstPix = pixIn.frameSync || firstOut_reg;
        pixCnt_next = pixCnt_reg;
        lineCnt_next = lineCnt_reg;
        field_next = field_reg;
        firstOut_next = firstOut_reg;
        started_next = started_reg;
        if (take) begin
            started_next = 1'b1;
            lineCnt_next = curLine;
            field_next = curField;
            pixCnt_next = pixIn.lineSync ? DIM_ONE : pixCnt_reg + DIM_ONE;
            if (pixIn.frameSync) begin
                firstOut_next = 1'b1;
            end
            if (keep) begin
                firstOut_next = 1'b0;
            end
        end
        word.pixel = pixIn.pixel;
        // syncs on the first kept pixel of the field
        word.frameSync = firstPix;
        word.lineSync = firstPix;
        // field flag constant through the field
        word.field = curField;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pixCnt_reg <= DIM_ZERO;
            lineCnt_reg <= DIM_ZERO;
            field_reg <= FIELD_ODD;
            firstOut_reg <= 1'b1;
            started_reg <= 1'b0;
        end else begin
            pixCnt_reg <= pixCnt_next;
            lineCnt_reg <= lineCnt_next;
            field_reg <= field_next;
            firstOut_reg <= firstOut_next;
            started_reg <= started_next;
        end
    end

    // ****************************************************************
    // output slot and skid slot
    // ****************************************************************
    // ready is registered, so a pixel may arrive in the cycle the sink
    // stalls; the skid slot catches it instead of overwriting the output
    always_comb begin
        // output slot frees on a taken pixel
        slotFree = !outValid_reg || pixOutReady;
        out_next = out_reg;
        outValid_next = outValid_reg && !pixOutReady;
        skid_next = skid_reg;
        skidValid_next = skidValid_reg;
        if (slotFree) begin
            if (skidValid_reg) begin
                out_next = skid_reg;
                outValid_next = 1'b1;
                skidValid_next = keep;
                if (keep) begin
                    skid_next = word;
                end
            end else if (keep) begin
                out_next = word;
                outValid_next = 1'b1;
            end
        end else if (keep) begin
            skid_next = word;
            skidValid_next = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            out_reg <= '0;
            outValid_reg <= 1'b0;
            skid_reg <= '0;
            skidValid_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            outValid_reg <= outValid_next;
            skid_reg <= skid_next;
            skidValid_reg <= skidValid_next;
        end
    end

    // ****************************************************************
    // input ready
    // ****************************************************************
    always_comb begin
        // ready stays high while the skid slot is empty
        inReady_next = !skidValid_next;
        // inside a dropped line the next pixel is dropped too
        if (take && !keep && !lastPix) begin
            inReady_next = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            inReady_reg <= 1'b0;
        end else begin
            inReady_reg <= inReady_next;
        end
    end

    // the output stage drains on its own once the sink is ready
    always_comb begin
        pixOut = out_reg;
        pixOutValid = outValid_reg;
        pixInReady = inReady_reg;
    end
endmodule

// ---- logic/field_conv_pkg.sv ----
// Purpose: shared constants and carriers for the progressive to interlaced converter
// Assumes: one clock, 24-bit pixels, 16-bit frame dimensions
// Notes: field flag 0 marks an odd field, 1 an even field
package field_conv_pkg;
    localparam int PIX_W = 24;
    localparam int DIM_W = 16;
    localparam logic FIELD_ODD = 1'b0;
    localparam logic FIELD_EVEN = 1'b1;
    localparam logic [DIM_W-1:0] DIM_ZERO = 16'h0000;
    localparam logic [DIM_W-1:0] DIM_ONE = 16'h0001;

    typedef struct packed {
        logic [PIX_W-1:0] pixel;
        logic frameSync;
        logic lineSync;
    } pix_in_t;

    typedef struct packed {
        logic [PIX_W-1:0] pixel;
        logic frameSync;
        logic lineSync;
        logic field;
    } pix_out_t;
endpackage

// ---- verification/field_conv_properties.sv ----
// Purpose: port checks of the converter
// Assumes: sync reset, active high
// Notes: bound to every converter
`timescale 1ns/1ps
module field_conv_checker
    import field_conv_pkg::*;
(
    input wire logic mclk, srst, pixInValid, pixInReady, pixOutValid, pixOutReady,
    input wire logic [DIM_W-1:0] lineWidth, frameHeight,
    input wire pix_in_t pixIn,
    input wire pix_out_t pixOut
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence held_s; pixOutValid && !pixOutReady; endsequence
    sequence new_s; pixOutValid && !$past(pixOutValid); endsequence
    a_reset_clears: assert property ($past(srst) |-> !pixOutValid && !pixInReady)
        else $error("reset");
    a_stall_holds: assert property (held_s |=> pixOutValid && $stable(pixOut))
        else $error("stall");
    a_valid_cause: assert property ($rose(pixOutValid)
        |-> $past(pixInValid && pixInReady)) else $error("valid");
    a_pixel_pass: assert property (new_s |-> pixOut.pixel == $past(pixIn.pixel))
        else $error("pixel");
    a_sync_cause: assert property (new_s ##0 pixOut.lineSync |-> $past(pixIn.lineSync))
        else $error("sync");
    a_syncs_paired: assert property (pixOutValid |-> pixOut.frameSync == pixOut.lineSync)
        else $error("pair");
    a_field_steady: assert property (pixOutValid && $past(pixOutValid) && !pixOut.frameSync
        |-> $stable(pixOut.field)) else $error("field");
    a_ready_flow: assert property (!$past(srst) && $past(pixOutReady) |-> pixInReady)
        else $error("ready");
endmodule
bind video_field_converter field_conv_checker field_conv_checker_inst (.*);

// ---- verification/video_partner.sv ----
// Purpose: source and sink around the converter
// Assumes: W x H frames with random gaps
// Notes: idle pixel lines show the inverse of the held pixel
`timescale 1ns/1ps
module video_partner
    import field_conv_pkg::*;
#(parameter int W = 3, parameter int H = 5)
(
    input wire logic mclk, srst, run, stall, pixInReady,
    output pix_in_t pixIn,
    output logic pixInValid = 1'b0, pixOutReady = 1'b0
);
    pix_in_t cur = '0;
    int x = 0, y = 0;
    assign pixIn = pixInValid ? cur : ~cur;
    // syncs on starts, held while stalled
    always @(posedge mclk) begin
        pixOutReady <= !stall || 1'($urandom_range(1));
        if (srst || pixInValid && pixInReady) begin
            x = srst ? 0 : (x + 1) % W;
            y = srst ? 0 : (x != 0 ? y : (y + 1) % H);
        end
        if (srst || !pixInValid || pixInReady) begin
            pixInValid <= !srst && run && $urandom_range(3) != 0;
            cur <= {24'($urandom), x == 0 && y == 0, x == 0};
        end
    end
endmodule

// ---- verification/testbench.sv ----
// Purpose: random frames through the converter
// Assumes: 3 x 5 frames
// Notes: free flow, mid-frame reset, stalling sink
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
$display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
    import field_conv_pkg::*;
    logic mclk = 0, srst = 1, run = 0, stall = 0, fld = 1, pixInValid, pixInReady;
    logic pixOutValid, pixOutReady;
    logic [DIM_W-1:0] line = 16'h0000;
    pix_in_t pixIn;
    pix_out_t pixOut, e, expQ[$];
    int frames = 0, comparisons = 0, miscompares = 0;
    initial forever #2.5 mclk = ~mclk;
    video_field_converter video_field_converter_inst (.*, .lineWidth(16'h0003),
        .frameHeight(16'h0005));
    video_partner video_partner_inst (.*);
    always @(posedge mclk) begin
        fld = fld | srst;
        if (srst) expQ.delete();
        else begin
            if (pixInValid && pixInReady) begin
                line = pixIn.frameSync ? 16'h0000 : line + 16'(pixIn.lineSync);
                fld = fld ^ pixIn.frameSync;
                frames += pixIn.frameSync;
                if (line[0] == fld)
                    expQ.push_back({pixIn.pixel, {2{pixIn.lineSync && line == 16'(fld)}}, fld});
            end
            if (pixOutValid && pixOutReady) e = expQ.size() ? expQ.pop_front() : 'x;
            if (pixOutValid && pixOutReady) `CHK("pixOut", e, pixOut)
            if (!stall && pixInValid) `CHK("pixInReady", 1'b1, pixInReady)
        end
    end
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hEA2A));
        repeat (16) @(posedge mclk);
        run <= 1;
        for (int p = 1; p < 4; p++) begin
            stall <= p == 3;
            srst <= p == 2;
            @(posedge mclk);
            srst <= 0;
            for (int i = 0; i < 3000 && frames < 4 * p; i++) @(posedge mclk);
            `CHK("frames", 1'b1, frames >= 4 * p)
        end
        run <= 0;
        for (int i = 0; i < 300 && expQ.size() > 0; i++) @(posedge mclk);
        `CHK("drained", 0, expQ.size())
        summarize();
    end
endmodule
